// >>> sbs_device.sv
// Purpose: pipelined synchronous burst sram, two byte lanes
// Assumes: pins come in synchronous to clk; rstn only models power-up
// Notes:   output enable acts combinationally on the lane drivers
//
// The plain strobed port and the register addresses are this design's own decisions.
`include "sbs_cfg.svh"
module sbs_device (
  input  wire logic clk,
  input  wire logic rstn,
  sbs_if.dev        pins
);
  import sbs_pkg::*;

  // ==========================================================
  // input registers
  logic       adscN_ff, adspN_ff, advN_ff, ce1N_ff, ce2_ff, ce3N_ff;
  logic       gwN_ff, weN_ff;
  logic [1:0] bwN_ff;
  sbs_addr_t  addr_ff;
  sbs_data_t  din_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      adscN_ff <= 1'b1;
      adspN_ff <= 1'b1;
      advN_ff  <= 1'b1;
      ce1N_ff  <= 1'b1;
      ce2_ff   <= 1'b0;
      ce3N_ff  <= 1'b1;
      gwN_ff   <= 1'b1;
      weN_ff   <= 1'b1;
      bwN_ff   <= 2'h3;
      addr_ff  <= '0;
      din_ff   <= '0;
    end else begin
      adscN_ff <= pins.ctrlAddrStrobeN;
      adspN_ff <= pins.cpuAddrStrobeN;
      advN_ff  <= pins.burstStepN;
      ce1N_ff  <= pins.chipEnablePrimaryN;
      ce2_ff   <= pins.depthEnableHi;
      ce3N_ff  <= pins.depthEnableLoN;
      gwN_ff   <= pins.globalWriteN;
      weN_ff   <= pins.writeEnableN;
      bwN_ff   <= pins.byteWriteN;
      addr_ff  <= pins.syncAddr;
      din_ff   <= pins.dataByteLanes;
    end
  end

  // ==========================================================
  // cycle decode on the registered pins
  function automatic logic [1:0] laneWrites(input logic gwN, input logic weN,
                                            input logic [1:0] bwN);
    if (!gwN)
      laneWrites = 2'h3;
    else if (!weN)
      laneWrites = ~bwN;
    else
      laneWrites = 2'h0;
  endfunction

  logic       selected, adspTake, adscTake, newCycle, desel;
  logic [1:0] wrLanes;
  assign selected = !ce1N_ff && ce2_ff && !ce3N_ff;
  assign adspTake = !adspN_ff && !ce1N_ff;
  assign adscTake = adspN_ff && !adscN_ff;
  assign newCycle = adspTake || adscTake;
  assign desel    = newCycle && !selected;
  assign wrLanes  = laneWrites(gwN_ff, weN_ff, bwN_ff);

  sbs_cyc_t cyc_ff;
  logic     adspPend_ff;

  // a processor-strobe cycle decides read or write in the following cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cyc_ff      <= SBS_IDLE;
      adspPend_ff <= 1'b0;
    end else if (desel) begin
      cyc_ff      <= SBS_IDLE;
      adspPend_ff <= 1'b0;
    end else if (adspTake) begin
      cyc_ff      <= SBS_READ;
      adspPend_ff <= 1'b1;
    end else if (adscTake) begin
      cyc_ff      <= (wrLanes != 2'h0) ? SBS_WRITE : SBS_READ;
      adspPend_ff <= 1'b0;
    end else begin
      if (adspPend_ff && wrLanes != 2'h0)
        cyc_ff <= SBS_WRITE;
      adspPend_ff <= 1'b0;
    end
  end

  // ==========================================================
  // burst counter
  logic [1:0] addrLow;
  logic       stepNow;
  assign stepNow = !advN_ff && !newCycle && !adspPend_ff;
  sbs_burst_cnt uCnt (
    .clk      (clk),
    .rstn     (rstn),
    .load     (newCycle && selected),
    .loadVal  (addr_ff[1:0]),
    .step     (stepNow),
    .orderSel (pins.burstOrderSelect),
    .addrLow  (addrLow)
  );
  logic [`SBS_ADDR_W-3:0] addrHi_ff;
  always_ff @(posedge clk) begin
    if (!rstn)
      addrHi_ff <= '0;
    else if (newCycle && selected)
      addrHi_ff <= addr_ff[`SBS_ADDR_W-1:2];
  end
  sbs_addr_t curAddr;
  assign curAddr = {addrHi_ff, addrLow};

  // ==========================================================
  // array and output register
  logic [`SBS_LANE_W-1:0] memA [`SBS_DEPTH];
  logic [`SBS_LANE_W-1:0] memB [`SBS_DEPTH];
  logic [1:0] wrNow;
  logic       adscWr;
  sbs_addr_t  wrAddr;
  // a controller-strobe write carries its data beside the strobe, so it lands
  // at the external address at once; processor-strobe writes follow a cycle on
  assign adscWr = adscTake && selected && (wrLanes != 2'h0);
  assign wrNow  = adscWr ? wrLanes
                : (((cyc_ff == SBS_WRITE) || adspPend_ff) && !newCycle) ? wrLanes
                : 2'h0;
  assign wrAddr = adscWr ? addr_ff : curAddr;

  always_ff @(posedge clk) begin
    if (wrNow[`SBS_LANE_A])
      memA[wrAddr] <= din_ff[`SBS_LANE_W-1:0];
    if (wrNow[`SBS_LANE_B])
      memB[wrAddr] <= din_ff[`SBS_DATA_W-1:`SBS_LANE_W];
  end

  sbs_data_t dout_ff;
  logic      rdValid_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout_ff    <= '0;
      rdValid_ff <= 1'b0;
    end else begin
      dout_ff    <= {memB[curAddr], memA[curAddr]};
      rdValid_ff <= (cyc_ff == SBS_READ) && (wrNow == 2'h0);
    end
  end

  assign pins.dataDevOut = dout_ff;
  // enable is combinational from the pin, no clock in the path
  assign pins.dataDevOe  = !pins.outputEnableN && rdValid_ff;
endmodule

// >>> sbs_cfg.svh
// Purpose: constants for the synchronous burst sram pin block
// Assumes: two byte lanes of nine bits, small array depth for the model
// Notes:   widths are fixed, not parameters
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_LANE_W   9
`define SBS_DATA_W   18
`define SBS_ADDR_W   8
`define SBS_DEPTH    256
`define SBS_LANE_A   0
`define SBS_LANE_B   1
`define SBS_ORDER_LINEAR 1'b0
`define SBS_ORDER_INTLV  1'b1
`endif

// >>> sbs_pkg.sv
// Purpose: shared types for the burst sram pin block
// Assumes: sbs_cfg.svh holds the numbers
// Notes:   host command codes and device cycle states
`include "sbs_cfg.svh"
package sbs_pkg;
  typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
  typedef logic [`SBS_DATA_W-1:0] sbs_data_t;
  typedef enum logic [1:0] {
    SBS_IDLE  = 2'b00,
    SBS_READ  = 2'b01,
    SBS_WRITE = 2'b10
  } sbs_cyc_t;
  typedef enum logic [1:0] {
    SBS_CMD_NONE  = 2'b00,
    SBS_CMD_READ  = 2'b01,
    SBS_CMD_WRITE = 2'b10,
    SBS_CMD_DESEL = 2'b11
  } sbs_cmd_t;
endpackage

// >>> sbs_if.sv
// Purpose: pins between the burst sram and its controller
// Assumes: data lanes are resolved here from the two enables
// Notes:   no clocking block; pull-up model when nobody drives
interface sbs_if;
  import sbs_pkg::*;
  logic      ctrlAddrStrobeN;
  logic      cpuAddrStrobeN;
  logic      burstStepN;
  logic      chipEnablePrimaryN;
  logic      depthEnableHi;
  logic      depthEnableLoN;
  logic      globalWriteN;
  logic      writeEnableN;
  logic [1:0] byteWriteN;
  logic      outputEnableN;
  logic      burstOrderSelect;
  sbs_addr_t syncAddr;
  sbs_data_t dataHostOut;
  logic      dataHostOe;
  sbs_data_t dataDevOut;
  logic      dataDevOe;
  sbs_data_t dataByteLanes;
  assign dataByteLanes = dataDevOe ? dataDevOut : (dataHostOe ? dataHostOut : '1);
  modport dev (
    input  ctrlAddrStrobeN, cpuAddrStrobeN, burstStepN, chipEnablePrimaryN,
    input  depthEnableHi, depthEnableLoN, globalWriteN, writeEnableN, byteWriteN,
    input  outputEnableN, burstOrderSelect, syncAddr, dataByteLanes,
    output dataDevOut, dataDevOe
  );
  modport host (
    output ctrlAddrStrobeN, cpuAddrStrobeN, burstStepN, chipEnablePrimaryN,
    output depthEnableHi, depthEnableLoN, globalWriteN, writeEnableN, byteWriteN,
    output outputEnableN, burstOrderSelect, syncAddr, dataHostOut, dataHostOe,
    input  dataByteLanes
  );
endinterface

// >>> sbs_burst_cnt.sv
// Purpose: two-bit burst address counter
// Assumes: load wins over step
// Notes:   order select is used live, never registered
`include "sbs_cfg.svh"
module sbs_burst_cnt (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       load,
  input  wire logic [1:0] loadVal,
  input  wire logic       step,
  input  wire logic       orderSel,
  output logic [1:0]      addrLow
);
  logic [1:0] start_ff;
  logic [1:0] count_ff;

  // ==========================================================
  // burst position
  always_ff @(posedge clk) begin
    if (!rstn) begin
      start_ff <= 2'h0;
      count_ff <= 2'h0;
    end else if (load) begin
      start_ff <= loadVal;
      count_ff <= 2'h0;
    end else if (step) begin
      count_ff <= count_ff + 2'h1;
    end
  end

  // interleaved order is a xor of the start with the count
  assign addrLow = (orderSel == `SBS_ORDER_INTLV) ? (start_ff ^ count_ff)
                                                  : (start_ff + count_ff);
endmodule

// >>> sbs_host.sv
// Purpose: controller end driving the burst sram pins
// Assumes: user issues one command at a time, holds it one cycle
// Notes:   rdValid follows a read command by eight edges, after the sync stages
module sbs_host (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         cmdValid,
  input  sbs_pkg::sbs_cmd_t cmdCode,
  input  sbs_pkg::sbs_addr_t cmdAddr,
  input  sbs_pkg::sbs_data_t cmdData,
  input  wire logic [1:0]   cmdBytes,
  input  wire logic         burstStep,
  input  wire logic         orderSel,
  output sbs_pkg::sbs_data_t rdData,
  output logic              rdValid,
  sbs_if.host               pins
);
  import sbs_pkg::*;

  logic       adscN_ff, advN_ff, ce1N_ff, weN_ff, oeN_ff, dOe_ff;
  logic [1:0] bwN_ff;
  sbs_addr_t  addr_ff;
  sbs_data_t  dOut_ff;
  logic [6:0] rdPipe_ff;
  sbs_data_t  s1_ff, s2_ff, s3_ff, rd_ff;
  logic       rv_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      adscN_ff <= 1'b1;
      advN_ff  <= 1'b1;
      ce1N_ff  <= 1'b1;
      weN_ff   <= 1'b1;
      bwN_ff   <= 2'h3;
      addr_ff  <= '0;
      dOut_ff  <= '0;
      dOe_ff   <= 1'b0;
      oeN_ff   <= 1'b1;
    end else begin
      adscN_ff <= !(cmdValid && cmdCode != SBS_CMD_NONE);
      ce1N_ff  <= cmdValid && cmdCode == SBS_CMD_DESEL;
      weN_ff   <= !(cmdValid && cmdCode == SBS_CMD_WRITE);
      bwN_ff   <= ~cmdBytes;
      advN_ff  <= !burstStep;
      if (cmdValid)
        addr_ff <= cmdAddr;
      dOut_ff  <= cmdData;
      dOe_ff   <= cmdValid && cmdCode == SBS_CMD_WRITE;
      // release the bus on the same edge that starts the write, hold it off through the write
      oeN_ff   <= cmdValid ? (cmdCode != SBS_CMD_READ) : oeN_ff;
    end
  end

  // three flip-flops on the lane input, agreeing pair counts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_ff     <= '0;
      s2_ff     <= '0;
      s3_ff     <= '0;
      rd_ff     <= '0;
      rv_ff     <= 1'b0;
      rdPipe_ff <= 7'h00;
    end else begin
      s1_ff     <= pins.dataByteLanes;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      // strobe, device input reg, cycle reg, output reg, then three sync stages
      rdPipe_ff <= {rdPipe_ff[5:0], cmdValid && cmdCode == SBS_CMD_READ};
      rv_ff     <= rdPipe_ff[6] && (s2_ff == s3_ff);
      rd_ff     <= s3_ff;
    end
  end

  assign pins.ctrlAddrStrobeN    = adscN_ff;
  assign pins.cpuAddrStrobeN     = 1'b1;
  assign pins.burstStepN         = advN_ff;
  assign pins.chipEnablePrimaryN = ce1N_ff;
  assign pins.depthEnableHi      = 1'b1;
  assign pins.depthEnableLoN     = 1'b0;
  assign pins.globalWriteN       = 1'b1;
  assign pins.writeEnableN       = weN_ff;
  assign pins.byteWriteN         = bwN_ff;
  assign pins.outputEnableN      = oeN_ff;
  assign pins.burstOrderSelect   = orderSel;
  assign pins.syncAddr           = addr_ff;
  assign pins.dataHostOut        = dOut_ff;
  assign pins.dataHostOe         = dOe_ff;
  assign rdData                  = rd_ff;
  assign rdValid                 = rv_ff;
endmodule

// >>> sbs_pins_asserts.sv
// Purpose: pin checks between the burst sram and its controller
// Assumes: signals come straight from the joining interface
// Notes:   read data lands two edges after the strobe edge
module sbs_pins_asserts (
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic          ctrlAddrStrobeN,
  input wire logic          chipEnablePrimaryN,
  input wire logic          depthEnableHi,
  input wire logic          depthEnableLoN,
  input wire logic          globalWriteN,
  input wire logic          writeEnableN,
  input wire logic [1:0]    byteWriteN,
  input wire logic          outputEnableN,
  input wire logic          burstOrderSelect,
  input wire logic          dataDevOe,
  input wire logic          dataHostOe,
  input sbs_pkg::sbs_data_t dataDevOut,
  input sbs_pkg::sbs_data_t dataByteLanes
);
  import sbs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // read start: selected strobe, then no write controls
  sequence s_sel_strobe;
    !ctrlAddrStrobeN && !chipEnablePrimaryN && depthEnableHi && !depthEnableLoN;
  endsequence
  sequence s_read_go;
    s_sel_strobe ##1 (globalWriteN && (writeEnableN || byteWriteN == 2'b11));
  endsequence
  // ==========================================
  // lane drivers
  a_oe_float: assert property (outputEnableN |-> !dataDevOe)
    else $error("lanes driven with output enable high");
  a_lane_match: assert property (dataDevOe |-> dataByteLanes == dataDevOut)
    else $error("lanes differ from device data");
  a_no_contend: assert property (dataHostOe |-> !dataDevOe)
    else $error("both ends drive the lanes");
  a_read_out: assert property (s_read_go ##1 !outputEnableN ##1 !outputEnableN |-> dataDevOe)
    else $error("read data missing two edges after strobe");
  // ==========================================
  // selection
  a_desel_float: assert property (!ctrlAddrStrobeN && chipEnablePrimaryN |-> ##2 !dataDevOe)
    else $error("lanes driven after deselect");
  a_depth_float: assert property (!ctrlAddrStrobeN && (!depthEnableHi || depthEnableLoN)
    |-> ##2 !dataDevOe)
    else $error("lanes driven with depth enables off");
  // ==========================================
  // controller obligations
  a_order_steady: assert property ($stable(burstOrderSelect))
    else $error("burst order select moved");
  a_global_high: assert property (globalWriteN)
    else $error("global write not held high");
endmodule

// >>> sync_burst_sram_ctrl_pins_tb_top.sv
// Purpose: bench joining controller and sram ends over the pin interface
// Assumes: one command at a time, read result flagged by rdValid
// Notes:   burst step and order select held at zero
module sync_burst_sram_ctrl_pins_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sbs_pkg::*;
  logic       clk;
  logic       rstn;
  logic       cmdValid;
  sbs_cmd_t   cmdCode;
  sbs_addr_t  cmdAddr;
  sbs_data_t  cmdData;
  logic [1:0] cmdBytes;
  sbs_data_t  rdData;
  logic       rdValid;
  int         badCount;
  int         samplesChecked;
  int         cycles;
  sbs_addr_t  adr [3] = '{8'h00, 8'hff, 8'h10};
  sbs_addr_t  badr [3] = '{8'h21, 8'h22, 8'h23};
  logic [1:0] bsel [3] = '{2'h1, 2'h2, 2'h0};
  sbs_data_t  bexp [3] = '{18'h3fe00, 18'h001ff, 18'h3ffff};
  sbs_if u_sbs_if ();
  sbs_device u_sbs_device (.clk(clk), .rstn(rstn), .pins(u_sbs_if.dev));
  sbs_host u_sbs_host (.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdBytes(cmdBytes), .burstStep(1'b0),
    .orderSel(1'b0), .rdData(rdData), .rdValid(rdValid), .pins(u_sbs_if.host));
  sbs_pins_asserts u_sbs_pins_asserts (.clk(clk), .rstn(rstn),
    .ctrlAddrStrobeN(u_sbs_if.ctrlAddrStrobeN), .chipEnablePrimaryN(u_sbs_if.chipEnablePrimaryN),
    .depthEnableHi(u_sbs_if.depthEnableHi), .depthEnableLoN(u_sbs_if.depthEnableLoN),
    .globalWriteN(u_sbs_if.globalWriteN), .writeEnableN(u_sbs_if.writeEnableN),
    .byteWriteN(u_sbs_if.byteWriteN), .outputEnableN(u_sbs_if.outputEnableN),
    .burstOrderSelect(u_sbs_if.burstOrderSelect), .dataDevOe(u_sbs_if.dataDevOe),
    .dataHostOe(u_sbs_if.dataHostOe), .dataDevOut(u_sbs_if.dataDevOut),
    .dataByteLanes(u_sbs_if.dataByteLanes));
  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      final_report();
    end
  end
  // ==========================================
  // tasks
  task automatic check(string nm, sbs_data_t seen, sbs_data_t exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic issue(sbs_cmd_t c, sbs_addr_t a, sbs_data_t d, logic [1:0] b);
    cmdValid <= 1'b1;
    cmdCode  <= c;
    cmdAddr  <= a;
    cmdData  <= d;
    cmdBytes <= b;
    @(posedge clk);
    cmdValid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // waits for rdValid under a bound, then compares the word
  task automatic rd(sbs_addr_t a, sbs_data_t exp);
    int n;
    n = 0;
    cmdValid <= 1'b1;
    cmdCode  <= SBS_CMD_READ;
    cmdAddr  <= a;
    @(posedge clk);
    cmdValid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rdValid !== 1'b1 && n < 12);
    check("rdValid", {17'h0, rdValid}, 18'h1);
    check("rdData", rdData, exp);
    repeat (3) @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    rstn = 1'b0;
    cmdValid = 1'b0;
    cmdCode = SBS_CMD_NONE;
    cmdAddr = 8'h00;
    cmdData = 18'h00000;
    cmdBytes = 2'h0;
    badCount = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // all three written before any read, so aliasing shows
    foreach (adr[i]) issue(SBS_CMD_WRITE, adr[i], {2'h2, adr[i], ~adr[i]}, 2'h3);
    foreach (adr[i]) rd(adr[i], {2'h2, adr[i], ~adr[i]});
    foreach (badr[i]) begin
      issue(SBS_CMD_WRITE, badr[i], 18'h3ffff, 2'h3);
      issue(SBS_CMD_WRITE, badr[i], 18'h00000, bsel[i]);
      rd(badr[i], bexp[i]);
    end
    issue(SBS_CMD_DESEL, 8'h10, 18'h00000, 2'h0);
    check("floatLanes", u_sbs_if.dataByteLanes, 18'h3ffff);
    rd(8'h10, {2'h2, 8'h10, 8'hef});
    final_report();
  end
endmodule
